/* bench/chan_value_proc_tb_top.sv */
// Testbench for the channel value processing block.
// Assumes the front end model above and the register port of the design.
`timescale 1ns/1ps
`default_nettype none
module chan_value_proc_tb_top;
  import chan_proc_pkg::*;
  logic        clk_i, nrst_i, wr_i, rd_i, rd_d;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, out_val_o, sample_i, chan0_i, r;
  logic        sample_vld_i, sensor_break_i, over_range_i;
  logic        out_vld_o, alarm_o, alarm_hi_o, alarm_lo_o, meas_run_o;
  logic [2:0]  label_tag_o;
  logic [15:0] lbl [5] = '{16'h4a2a, 16'h4a23, 16'h542a, 16'h502a, 16'h4e23};
  logic [31:0] rq[$], mq[$], oq[$];
  int          n_fail, num_checks;

  chan_value_proc dut (.clk_i(clk_i), .nrst_i(nrst_i), .sample_vld_i(sample_vld_i),
    .sample_i(sample_i), .chan0_i(chan0_i), .sensor_break_i(sensor_break_i),
    .over_range_i(over_range_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .out_val_o(out_val_o), .out_vld_o(out_vld_o),
    .alarm_o(alarm_o), .alarm_hi_o(alarm_hi_o), .alarm_lo_o(alarm_lo_o),
    .meas_run_o(meas_run_o), .label_tag_o(label_tag_o));
  front_end_model fe (.clk_i(clk_i), .sample_vld_o(sample_vld_i), .sample_o(sample_i),
    .chan0_o(chan0_i), .sensor_break_o(sensor_break_i), .over_range_o(over_range_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  // Read expectation is noted first; the monitor compares under the mask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e);
    mq.push_back(m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
  endtask : rd
  task automatic smp(input logic [31:0] v, input logic [31:0] e);
    oq.push_back(e);
    fe.send(v, 4);
  endtask : smp
  function automatic logic [31:0] cfg(input logic [2:0] o, l, input logic [1:0] a);
    cfg = (32'(HYST_RESET) << CFG_HYST_LSB) | (32'(o) << CFG_OUT_LSB) |
          (32'(l) << CFG_LOCK_LSB) | (32'(a) << CFG_ACTMAX_LSB);
  endfunction : cfg
  ////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each read answer and each output strobe
  always @(posedge clk_i) begin
    if (rd_d) begin
      if (rq.size() == 0) chk(rdata_o, 32'hdead_0000);
      else chk(rdata_o & mq.pop_front(), rq.pop_front());
    end
    rd_d <= rd_i;
    if (out_vld_o) begin
      if (oq.size() == 0) chk(out_val_o, 32'hdead_0001);
      else chk(out_val_o, oq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
  initial begin
    nrst_i  = 1'b0;
    addr_i  = 8'h00;
    wdata_i = 32'h0;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    rd_d    = 1'b0;
    n_fail  = 0;
    num_checks = 0;
    void'($urandom(5753));
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_CFG, 32'(HYST_RESET) << CFG_HYST_LSB, 32'h07f0_0000);
    wr(ADDR_CFG, cfg(OUT_MEAS, 3'h0, 2'h0));
    wr(ADDR_CTRL, (32'h1 << CTRL_LIMSET_HI) | (32'h1 << CTRL_LIMSET_LO));
    wr(ADDR_LIMITS, 32'hff9c_0064);
    r = $urandom_range(99, 0);
    smp(r, r);
    fe.set_levels(32'h0000_000a, 1'b0, 1'b0);
    wr(ADDR_CFG, cfg(OUT_DIFF, 3'h0, 2'h0));
    smp(32'h0000_001e, 32'h0000_0014);
    $display("test output select done");
    wr(ADDR_CFG, cfg(OUT_MEAS, 3'h0, ACT_START));
    smp(32'h0000_0096, 32'h0000_0096);
    rd(ADDR_STATUS, 32'h0000_0014, 32'h0000_001c);
    smp(32'h0000_005f, 32'h0000_005f);
    rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_000c);
    smp(32'h0000_0059, 32'h0000_0059);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000c);
    smp(32'hffff_ff6a, 32'hffff_ff6a);
    rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_000c);
    smp(32'hffff_ffb0, 32'hffff_ffb0);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000c);
    rd(ADDR_MAX, 32'h0000_0096, 32'hffff_ffff);
    rd(ADDR_MIN, 32'hffff_ff6a, 32'hffff_ffff);
    wr(ADDR_CTRL, 32'h1 << CTRL_CLR_ALL);
    rd(ADDR_MAX, 32'hffff_ffb0, 32'hffff_ffff);
    $display("test limits and extremes done");
    wr(ADDR_CFG, cfg(OUT_ALARM, 3'h0, 2'h0));
    smp(32'h0000_0096, PCT_FULL);
    smp(32'h0000_0032, PCT_ZERO);
    wr(ADDR_CFG, cfg(OUT_ALARM, LOCK_RANGE, 2'h0));
    wr(ADDR_CFG, cfg(OUT_MEAS, 3'h0, 2'h0));
    rd(ADDR_STATUS, 32'h0000_0080, 32'h0000_0080);
    smp(32'h0000_0014, PCT_ZERO);
    wr(ADDR_CTRL, 32'h1 << CTRL_OVERRIDE);
    wr(ADDR_CFG, cfg(OUT_MEAS, 3'h0, 2'h0));
    smp(32'h0000_0021, 32'h0000_0021);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, cfg(OUT_MEAS, LOCK_LIMITS, 2'h0));
    wr(ADDR_LIMITS, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0080, 32'h0000_0080);
    smp(32'h0000_0096, 32'h0000_0096);
    rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_000c);
    $display("test locking done");
    wr(ADDR_CTRL, 32'h1 << CTRL_OVERRIDE);
    wr(ADDR_CFG, cfg(OUT_MEAS, 3'h0, 2'h0) | 32'h2 |
                 (32'(PER_CYCLE_AVERAGE_MODE) << CFG_AVG_LSB));
    wr(ADDR_CTRL, (32'h09 << CTRL_NCH_LSB) | (32'h05 << CTRL_RATE_LSB) |
                  (32'h1 << CTRL_CLR_AVG));
    smp(32'h0000_0028, 32'h0000_0028);
    smp(32'h0000_003c, 32'h0000_0032);
    smp(32'h0000_0014, 32'h0000_0028);
    rd(ADDR_TCONST, 32'h0000_0004, 32'hffff_ffff);
    rd(ADDR_COUNT, 32'h0000_0003, 32'hffff_ffff);
    rd(ADDR_AVG, 32'h0000_002b, 32'hffff_ffff);
    wr(ADDR_CTRL, 32'h1 << CTRL_CYCLE);
    rd(ADDR_MAX, 32'h0000_0028, 32'hffff_ffff);
    rd(ADDR_COUNT, 32'h0000_0000, 32'hffff_ffff);
    wr(ADDR_CTRL, 32'h1 << CTRL_AUTOCLR);
    smp(32'h0000_0050, 32'h0000_0032);
    wr(ADDR_CTRL, (32'h1 << CTRL_AUTOCLR) | (32'h1 << CTRL_START));
    rd(ADDR_COUNT, 32'h0000_0000, 32'hffff_ffff);
    $display("test smoothing and averaging done");
    wr(ADDR_CTRL, 32'h1 << CTRL_LINMARK);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_LABEL, {lbl[i][15:8], 3'h0, 5'h02, lbl[i]});
      repeat (3) @(posedge clk_i);
      chk({29'h0, label_tag_o}, 32'(i + 1));
    end
    wr(ADDR_LABEL, {8'h41, 3'h0, 5'h0b, 16'h4141});
    rd(ADDR_STATUS, 32'h0000_0040, 32'h0000_0040);
    rd(ADDR_LABEL, 32'h2100_0000, 32'hff00_0000);
    $display("test label done");
    fe.set_levels(32'h0000_000a, 1'b1, 1'b1);
    repeat (6) @(posedge clk_i);
    chk({31'h0, alarm_o}, 32'h1);
    rd(ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
    for (int i = 0; i < 20 && (rq.size() + oq.size()) > 0; i++) @(posedge clk_i);
    if (rq.size() + oq.size() > 0) n_fail++;
    $display("test faults done");
    test_done();
  end
endmodule : chan_value_proc_tb_top
`default_nettype wire

/* bench/front_end_model.sv */
// Front end model: sample strobes, channel-zero value and fault levels.
// Assumes the bench calls send() and set_levels() from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock
  input  wire logic        clk_i,
  // Towards the block
  output var  logic        sample_vld_o,
  output var  logic [31:0] sample_o,
  output var  logic [31:0] chan0_o,
  output var  logic        sensor_break_o,
  output var  logic        over_range_o
);
  initial begin
    sample_vld_o   = 1'b0;
    sample_o       = 32'h0;
    chan0_o        = 32'h0;
    sensor_break_o = 1'b0;
    over_range_o   = 1'b0;
  end
  // Gap sets prompt or slow pacing; stale data is inverted, never left valid
  task automatic send(input logic [31:0] v, input int gap);
    @(posedge clk_i);
    sample_vld_o <= 1'b1;
    sample_o     <= v;
    @(posedge clk_i);
    sample_vld_o <= 1'b0;
    sample_o     <= ~v;
    repeat (gap) @(posedge clk_i);
  endtask : send
  task automatic set_levels(input logic [31:0] c0, input logic brk, input logic ovr);
    @(posedge clk_i);
    chan0_o        <= c0;
    sensor_break_o <= brk;
    over_range_o   <= ovr;
  endtask : set_levels
endmodule : front_end_model
`default_nettype wire

/* verilog/chan_proc_pkg.sv */
// Constants shared by the channel value processing block.
// Assumes a single 200 MHz clock domain and a plain register port.
package chan_proc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SAMPLE   = 8'h04;
  localparam logic [7:0] ADDR_LIMITS   = 8'h08;
  localparam logic [7:0] ADDR_CFG      = 8'h0c;
  localparam logic [7:0] ADDR_LABEL    = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_MAX      = 8'h18;
  localparam logic [7:0] ADDR_MIN      = 8'h1c;
  localparam logic [7:0] ADDR_AVG      = 8'h20;
  localparam logic [7:0] ADDR_COUNT    = 8'h24;
  localparam logic [7:0] ADDR_OUTVAL   = 8'h28;
  localparam logic [7:0] ADDR_MAXTIME  = 8'h2c;
  localparam logic [7:0] ADDR_MINTIME  = 8'h30;
  localparam logic [7:0] ADDR_TCONST   = 8'h34;
  localparam logic [7:0] ADDR_TIME     = 8'h38;
  localparam logic [7:0] ADDR_RANGE    = 8'h3c;
  // CFG field positions
  localparam int CFG_SMOOTH_LSB = 0;   // 7 bits, smoothing length
  localparam int CFG_AVG_LSB    = 8;   // 2 bits, averaging mode
  localparam int CFG_OUT_LSB    = 12;  // 3 bits, output select
  localparam int CFG_LOCK_LSB   = 16;  // 3 bits, locking level
  localparam int CFG_HYST_LSB   = 20;  // 7 bits, hysteresis
  localparam int CFG_ACTMAX_LSB = 28;  // 2 bits
  localparam int CFG_ACTMIN_LSB = 30;  // 2 bits
  // CTRL bits
  localparam int CTRL_CLR_MAX   = 0;
  localparam int CTRL_CLR_MIN   = 1;
  localparam int CTRL_CLR_AVG   = 2;
  localparam int CTRL_CLR_ALL   = 3;
  localparam int CTRL_START     = 4;
  localparam int CTRL_STOP      = 5;
  localparam int CTRL_CYCLE     = 6;
  localparam int CTRL_OVERRIDE  = 7;
  localparam int CTRL_AUTOCLR   = 8;
  localparam int CTRL_EXTLABEL  = 9;
  localparam int CTRL_LINMARK   = 10;
  localparam int CTRL_LIMSET_HI = 11;
  localparam int CTRL_LIMSET_LO = 12;
  localparam int CTRL_RATE_LSB  = 16;  // 8 bits conversion rate
  localparam int CTRL_NCH_LSB   = 24;  // 7 bits active channels
  // Reset values and limits
  localparam logic [6:0] HYST_RESET  = 7'h0a;
  localparam logic [6:0] HYST_MAX    = 7'h63;
  localparam logic [6:0] SMOOTH_MAX  = 7'h63;
  localparam logic [4:0] LABEL_LONG  = 5'h14;
  localparam logic [4:0] LABEL_SHORT = 5'h0a;
  localparam logic [2:0] LOCK_LIMITS = 3'h7;
  localparam logic [2:0] LOCK_RANGE  = 3'h1;
  localparam logic [31:0] PCT_ZERO   = 32'h0000_0000;
  localparam logic [31:0] PCT_FULL   = 32'h0000_03e8;  // 100.0 in tenths
  // Enumerations
  typedef enum logic [1:0] {AVG_NONE = 2'h0, START_STOP_AVERAGE_MODE = 2'h1,
                            PER_CYCLE_AVERAGE_MODE = 2'h2} avg_mode_t;
  typedef enum logic [2:0] {OUT_MEAS = 3'h0, OUT_DIFF = 3'h1, OUT_MAX = 3'h2,
                            OUT_MIN = 3'h3, OUT_AVG = 3'h4, OUT_ALARM = 3'h5} out_sel_t;
  typedef enum logic [1:0] {ACT_ALARM = 2'h0, ACT_START = 2'h1, ACT_STOP = 2'h2} lim_act_t;
  typedef enum logic [2:0] {TAG_NONE = 3'h0, TAG_EXT_CJ = 3'h1, TAG_INT_CJ = 3'h2,
                            TAG_TEMP_REF = 3'h3, TAG_PRES_REF = 3'h4,
                            TAG_STD_FLOW = 3'h5} label_tag_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SMOOTH = 2'b01, ST_EVAL = 2'b11}
    proc_state_t;
endpackage : chan_proc_pkg

/* verilog/chan_value_proc.sv */
// Channel value processing: smoothing, extremes, averaging, output select,
// lock levels and limit alarms with hysteresis for one measuring channel.
// Assumes the front end delivers signed samples with a one-cycle strobe
// and that software drives the plain register port on clk_i.
`timescale 1ns/1ps
`default_nettype none
module chan_value_proc #(
  parameter int DW    = 32,
  parameter int DEPTH = 128
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // Front end samples
  input  wire logic          sample_vld_i,
  input  wire logic [DW-1:0] sample_i,
  input  wire logic [DW-1:0] chan0_i,
  input  wire logic          sensor_break_i,
  input  wire logic          over_range_i,
  // Register port
  input  wire logic [7:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic [31:0]        rdata_o,
  // Outputs to display, relays and storage
  output logic [DW-1:0]      out_val_o,
  output logic               out_vld_o,
  output logic               alarm_o,
  output logic               alarm_hi_o,
  output logic               alarm_lo_o,
  output logic               meas_run_o,
  output logic [2:0]         label_tag_o
);
  import chan_proc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Fault level synchroniser for sensor break and over-range (front end is off-domain)
  logic [1:0]    brk_s_r;
  logic [1:0]    ovr_s_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_s_r <= 2'h0;
      ovr_s_r <= 2'h0;
    end else begin
      brk_s_r <= {brk_s_r[0], sensor_break_i};
      ovr_s_r <= {ovr_s_r[0], over_range_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]   cfg_r;
  logic [31:0]   ctrl_r;
  logic [DW-1:0] lim_hi_r, lim_lo_r, range_hi_r, range_lo_r;
  logic          lim_hi_set_r, lim_lo_set_r;
  logic [31:0]   time_r;
  logic [15:0]   label_r;
  logic [4:0]    label_len_r;
  logic          label_err_r, lock_err_r, lin_mark_r;

  wire wr_ctrl  = wr_i && addr_i == ADDR_CTRL;
  wire wr_cfg   = wr_i && addr_i == ADDR_CFG;
  wire wr_lim   = wr_i && addr_i == ADDR_LIMITS;
  wire wr_range = wr_i && addr_i == ADDR_RANGE;
  wire wr_label = wr_i && addr_i == ADDR_LABEL;
  // Only the stored confirmation unlocks; data bits of other words never do
  wire override = ctrl_r[CTRL_OVERRIDE];
  wire [2:0] lock_lvl = cfg_r[CFG_LOCK_LSB +: 3];
  // Limit register: low half writes upper, high half lower, sign-extended
  wire lim_ok = lock_lvl < LOCK_LIMITS || override;
  wire cfg_ok = lock_lvl < LOCK_RANGE || override;
  // Label write: byte0/1 = first two chars, byte2 = length, byte3 = last char
  wire [7:0] lc0 = wdata_i[7:0];
  wire [7:0] lc1 = wdata_i[15:8];
  wire [7:0] llast = wdata_i[31:24];
  wire [4:0] lmax = ctrl_r[CTRL_EXTLABEL] ? LABEL_LONG : LABEL_SHORT;
  function automatic logic bad_char(input logic [7:0] c);
    bad_char = c < 8'h20 || c > 8'h7e || c == 8'h3b || c == 8'h2f ||
               c == 8'h7c || c == 8'h23;
  endfunction : bad_char
  // Leading hash in position 0 is a tag, not a forbidden character
  wire lbl_bad = (lc0 != 8'h23 && bad_char(lc0)) || bad_char(lc1) || bad_char(llast) ||
                 wdata_i[20:16] > lmax;
  wire [6:0] hyst_w = wdata_i[CFG_HYST_LSB +: 7];
  wire [6:0] smo_w  = wdata_i[CFG_SMOOTH_LSB +: 7];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r        <= {5'h0, HYST_RESET, 20'h0};
      ctrl_r       <= 32'h0;
      lim_hi_r     <= '0;
      lim_lo_r     <= '0;
      range_hi_r   <= '1 >> 1;
      range_lo_r   <= ~('1 >> 1);
      lim_hi_set_r <= 1'b0;
      lim_lo_set_r <= 1'b0;
      label_r      <= 16'h0;
      label_len_r  <= 5'h0;
      label_err_r  <= 1'b0;
      lock_err_r   <= 1'b0;
      lin_mark_r   <= 1'b0;
      time_r       <= 32'h0;
    end else begin
      time_r <= time_r + 32'h1;
      if (wr_ctrl)
        ctrl_r <= wdata_i & 32'h7f_ff_1f_80 | ctrl_r & 32'h0;
      if (wr_cfg) begin
        if (cfg_ok && hyst_w <= HYST_MAX && smo_w <= SMOOTH_MAX)
          cfg_r <= wdata_i;
        else
          lock_err_r <= 1'b1;
      end
      if (wr_range) begin
        range_hi_r <= DW'($signed(wdata_i[15:0]));
        range_lo_r <= DW'($signed(wdata_i[31:16]));
      end
      if (wr_lim) begin
        if (lim_ok) begin
          lim_hi_r     <= DW'($signed(wdata_i[15:0]));
          lim_lo_r     <= DW'($signed(wdata_i[31:16]));
          lim_hi_set_r <= ctrl_r[CTRL_LIMSET_HI];
          lim_lo_set_r <= ctrl_r[CTRL_LIMSET_LO];
        end else
          lock_err_r <= 1'b1;
      end
      if (wr_label) begin
        label_err_r <= lbl_bad;
        if (!lbl_bad) begin
          label_r     <= {lc1, lc0};
          label_len_r <= wdata_i[20:16];
        end
      end
      lin_mark_r <= ctrl_r[CTRL_LINMARK];
      if (rd_i && addr_i == ADDR_STATUS) begin
        label_err_r <= 1'b0;
        lock_err_r  <= 1'b0;
      end
    end
  end

  // Tag decode from first two label characters
  wire [2:0] tag_w =
    label_r == 16'h4a2a ? TAG_EXT_CJ   :
    label_r == 16'h4a23 ? TAG_INT_CJ   :
    label_r == 16'h542a ? TAG_TEMP_REF :
    label_r == 16'h502a ? TAG_PRES_REF :
    label_r == 16'h4e23 ? TAG_STD_FLOW : TAG_NONE;

  ////////////////////////////////////////////////////////////////////////
  // Sliding average over a circular buffer
  logic [DW-1:0] hist [DEPTH];
  logic [6:0]    wp_r, fill_r;
  logic [DW+7:0] sum_r;
  logic [DW-1:0] smooth_r, cur_r;
  logic          step_r;
  wire  [6:0]    slen = cfg_r[CFG_SMOOTH_LSB +: 7];
  wire  [6:0]    old_idx = wp_r - slen;
  wire  [DW+7:0] sum_nxt = sum_r + (DW+8)'($signed(sample_i)) -
                 ((fill_r >= slen && slen != 7'h0) ? (DW+8)'($signed(hist[old_idx])) : '0);
  // Compare before the increment so a saturated fill count cannot wrap to zero
  wire  [6:0]    navg = (fill_r < slen) ? fill_r + 7'h1 : slen;

  always_ff @(posedge clk_i) begin
    if (sample_vld_i)
      hist[wp_r] <= sample_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_r     <= 7'h0;
      fill_r   <= 7'h0;
      sum_r    <= '0;
      smooth_r <= '0;
      step_r   <= 1'b0;
    end else begin
      step_r <= sample_vld_i;
      if (wr_cfg && cfg_ok) begin
        fill_r <= 7'h0;
        sum_r  <= '0;
      end else if (sample_vld_i) begin
        wp_r   <= wp_r + 7'h1;
        fill_r <= (fill_r == 7'h7f) ? fill_r : fill_r + 7'h1;
        sum_r  <= sum_nxt;
        smooth_r <= (slen <= 7'h1) ? sample_i :
                    DW'($signed(sum_nxt) / $signed({1'b0, navg}));
      end
    end
  end

  // Time constant in tenths of a second units of rate
  logic [31:0] tconst_r;
  wire [7:0]   rate = ctrl_r[CTRL_RATE_LSB +: 8];
  wire [15:0]  tnum = 16'(slen) * 16'(ctrl_r[CTRL_NCH_LSB +: 7] + 7'h1);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) tconst_r <= 32'h0;
    else tconst_r <= (rate == 8'h0) ? 32'h0 : 32'(tnum / rate);
  end

  ////////////////////////////////////////////////////////////////////////
  // Extremes, averaging, run control
  logic [DW-1:0] max_r, min_r;
  logic [31:0]   max_t_r, min_t_r, cnt_r;
  logic [DW+31:0] acc_r;
  logic          have_r, run_r;
  wire start_evt = wr_ctrl && wdata_i[CTRL_START];
  wire cycle_evt = wr_ctrl && wdata_i[CTRL_CYCLE];
  wire [1:0] amode = cfg_r[CFG_AVG_LSB +: 2];
  wire auto_clr  = start_evt && ctrl_r[CTRL_AUTOCLR];
  wire cyc_clr   = cycle_evt && amode == PER_CYCLE_AVERAGE_MODE;
  wire clr_all   = (wr_ctrl && wdata_i[CTRL_CLR_ALL]) || auto_clr;
  wire clr_max   = clr_all || cyc_clr || (wr_ctrl && wdata_i[CTRL_CLR_MAX]);
  wire clr_min   = clr_all || cyc_clr || (wr_ctrl && wdata_i[CTRL_CLR_MIN]);
  wire clr_avg   = clr_all || cyc_clr || (wr_ctrl && wdata_i[CTRL_CLR_AVG]);
  wire avg_on    = amode == PER_CYCLE_AVERAGE_MODE ||
                   (amode == START_STOP_AVERAGE_MODE && run_r);
  wire [DW-1:0] avg_w = (cnt_r == 32'h0) ? cur_r :
                        DW'($signed(acc_r) / $signed({1'b0, cnt_r}));
  wire lim_start, lim_stop;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      max_r <= '0; min_r <= '0; max_t_r <= 32'h0; min_t_r <= 32'h0;
      cnt_r <= 32'h0; acc_r <= '0; have_r <= 1'b0; run_r <= 1'b0; cur_r <= '0;
    end else begin
      if (step_r) cur_r <= smooth_r;
      // Reload from current value so the display never shows a blank
      if (clr_max) begin max_r <= cur_r; max_t_r <= time_r; end
      else if (step_r && (!have_r || $signed(smooth_r) > $signed(max_r))) begin
        max_r <= smooth_r; max_t_r <= time_r;
      end
      if (clr_min) begin min_r <= cur_r; min_t_r <= time_r; end
      else if (step_r && (!have_r || $signed(smooth_r) < $signed(min_r))) begin
        min_r <= smooth_r; min_t_r <= time_r;
      end
      if (step_r) have_r <= 1'b1;
      if (clr_avg) begin
        cnt_r <= 32'h0;
        acc_r <= '0;
      end else if (step_r && avg_on) begin
        cnt_r <= cnt_r + 32'h1;
        acc_r <= acc_r + (DW+32)'($signed(smooth_r));
      end
      if (start_evt || lim_start) run_r <= 1'b1;
      else if ((wr_ctrl && wdata_i[CTRL_STOP]) || lim_stop) run_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit alarms with hysteresis
  logic hi_r, lo_r;
  wire [DW-1:0] hi_lim = lim_hi_set_r ? lim_hi_r : range_hi_r;
  wire [DW-1:0] lo_lim = lim_lo_set_r ? lim_lo_r : range_lo_r;
  wire [DW-1:0] hyst   = DW'(cfg_r[CFG_HYST_LSB +: 7]);
  wire hi_trip = $signed(smooth_r) > $signed(hi_lim);
  wire lo_trip = $signed(smooth_r) < $signed(lo_lim);
  wire hi_back = $signed(smooth_r) <= $signed(hi_lim - hyst);
  wire lo_back = $signed(smooth_r) >= $signed(lo_lim + hyst);
  wire hi_nxt  = hi_r ? !hi_back : hi_trip;
  wire lo_nxt  = lo_r ? !lo_back : lo_trip;
  assign lim_start = step_r && ((hi_nxt && !hi_r && cfg_r[CFG_ACTMAX_LSB +: 2] == ACT_START) ||
                     (lo_nxt && !lo_r && cfg_r[CFG_ACTMIN_LSB +: 2] == ACT_START));
  assign lim_stop  = step_r && ((hi_nxt && !hi_r && cfg_r[CFG_ACTMAX_LSB +: 2] == ACT_STOP) ||
                     (lo_nxt && !lo_r && cfg_r[CFG_ACTMIN_LSB +: 2] == ACT_STOP));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else if (step_r) begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output selection and ports
  wire [2:0] osel = cfg_r[CFG_OUT_LSB +: 3];
  wire [DW-1:0] sel_w =
    osel == OUT_DIFF  ? smooth_r - chan0_i :
    osel == OUT_MAX   ? max_r :
    osel == OUT_MIN   ? min_r :
    osel == OUT_AVG   ? avg_w :
    osel == OUT_ALARM ? (hi_nxt ? DW'(PCT_FULL) : DW'(PCT_ZERO)) :
    smooth_r;
  wire [DW-1:0] status_w = DW'({lock_err_r, label_err_r, lin_mark_r, run_r,
                               lo_r, hi_r, ovr_s_r[1], brk_s_r[1]});
  wire [31:0] rd_w =
    addr_i == ADDR_CFG     ? cfg_r :
    addr_i == ADDR_CTRL    ? ctrl_r :
    addr_i == ADDR_LABEL   ? {lin_mark_r ? 8'h21 : 8'h00, 3'h0, label_len_r, label_r} :
    addr_i == ADDR_STATUS  ? 32'(status_w) :
    addr_i == ADDR_MAX     ? 32'(max_r) :
    addr_i == ADDR_MIN     ? 32'(min_r) :
    addr_i == ADDR_AVG     ? 32'(avg_w) :
    addr_i == ADDR_COUNT   ? cnt_r :
    addr_i == ADDR_OUTVAL  ? 32'(out_val_o) :
    addr_i == ADDR_MAXTIME ? max_t_r :
    addr_i == ADDR_MINTIME ? min_t_r :
    addr_i == ADDR_TCONST  ? tconst_r :
    addr_i == ADDR_TIME    ? time_r :
    addr_i == ADDR_SAMPLE  ? 32'(cur_r) : 32'h0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0; out_val_o <= '0; out_vld_o <= 1'b0; alarm_o <= 1'b0;
      alarm_hi_o <= 1'b0; alarm_lo_o <= 1'b0; meas_run_o <= 1'b0; label_tag_o <= TAG_NONE;
    end else begin
      rdata_o     <= rd_i ? rd_w : 32'h0;
      out_vld_o   <= step_r;
      if (step_r) out_val_o <= sel_w;
      alarm_o     <= hi_r | lo_r | ovr_s_r[1] | brk_s_r[1];
      alarm_hi_o  <= hi_r;
      alarm_lo_o  <= lo_r;
      meas_run_o  <= run_r;
      label_tag_o <= tag_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_brk_alarm: assert property (@(posedge clk_i) disable iff (!nrst_i)
    brk_s_r[1] |=> alarm_o) else $error("break without alarm");
  a_hyst_rst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> cfg_r[CFG_HYST_LSB +: 7] == HYST_RESET)
    else $error("hysteresis reset wrong");
  a_hi_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    hi_r && step_r && !hi_back |=> hi_r) else $error("alarm dropped early");
  a_hi_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    hi_r |=> alarm_hi_o) else $error("upper flag missing");
  a_clr_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_max |=> max_r == $past(cur_r)) else $error("max not reloaded");
  a_out_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sample_vld_i |-> ##2 out_vld_o) else $error("output not updated");
  a_lock_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_lim && !lim_ok |=> $stable(lim_hi_r)) else $error("locked limit changed");
  a_alarm_pct: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r && osel == OUT_ALARM && !hi_nxt |=> out_val_o == DW'(PCT_ZERO))
    else $error("alarm value wrong");
endmodule : chan_value_proc
`default_nettype wire
